// *** rtl/efr_regs.svh ***
// Purpose: constants for the event queue readout block
// Assumes: 100 MHz clock
// Notes: offsets are word indices on the plain register port
`ifndef EFR_REGS_SVH
`define EFR_REGS_SVH
`define EFR_DEPTH 160
`define EFR_PTR_W 8
`define EFR_CNT_W 8
`define EFR_NUM_IN 16
`define EFR_SEQ_W 16
`define EFR_ENTRY_W 149
`define EFR_ADDR_W 4
`define EFR_A_ACK 4'h0
`define EFR_A_SEQ 4'h1
`define EFR_A_SRC 4'h2
`define EFR_A_SYS_LO 4'h3
`define EFR_A_SYS_HI 4'h4
`define EFR_A_WALL_LO 4'h5
`define EFR_A_WALL_HI 4'h6
`define EFR_A_PEND 4'h7
`define EFR_A_OVF 4'h8
`define EFR_A_IRQ_ST 4'h9
`define EFR_A_IRQ_MSK 4'hA
`define EFR_A_RPI 4'hB
`define EFR_RPI_RST 32'h000F4240
`define EFR_IRQ_NEW 0
`define EFR_IRQ_OVF 1
`define EFR_IRQ_SENT 2
`endif

// *** rtl/efr_pkg.sv ***
// Purpose: types for the event queue readout block
// Assumes: constants header
// Notes: entry layout shared by queue memory and readout
`include "efr_regs.svh"
package efr_pkg;
    typedef struct packed {
        logic [`EFR_SEQ_W-1:0] seq;
        logic [3:0] src;
        logic pol;
        logic [63:0] sys_ts;
        logic [63:0] wall_ts;
    } efr_entry_t;
endpackage

// *** rtl/efr_mem_if.sv ***
// Purpose: carrier between readout top and queue memory
// Assumes: one clock
// Notes: read data arrive one cycle after raddr, read every cycle
`timescale 1ns/1ns
`include "efr_regs.svh"
interface efr_mem_if;
    logic we;
    logic [`EFR_PTR_W-1:0] waddr;
    efr_pkg::efr_entry_t wdata;
    logic [`EFR_PTR_W-1:0] raddr;
    efr_pkg::efr_entry_t rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** rtl/efr_mem.sv ***
// Purpose: event queue storage, registered read
// Assumes: single clock, one write and one read port
// Notes: contents are not reset
`timescale 1ns/1ns
`include "efr_regs.svh"
module efr_mem (
    input wire logic clk_i,
    efr_mem_if.mem m
);
    efr_pkg::efr_entry_t ram [0:`EFR_DEPTH-1];
    efr_pkg::efr_entry_t rd_r;
    always_ff @(posedge clk_i) begin
        if (m.we) begin
            ram[m.waddr] <= m.wdata;
        end
        rd_r <= ram[m.raddr];
    end
    assign m.rdata = rd_r;
endmodule

// *** rtl/efr_event_fifo_readout.sv ***
// Purpose: readout side of a timestamped 16-input event queue
// Assumes: events arrive as one-cycle pulses already filtered, from the same clock
// Notes: head entry is cached in flops; the queue memory sits behind it
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "efr_regs.svh"
module efr_event_fifo_readout (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [`EFR_NUM_IN-1:0] evt_pulse_i,
    input wire logic [`EFR_NUM_IN-1:0] evt_level_i,
    input wire logic [63:0] coordinated_system_time_i,
    input wire logic [63:0] universal_wall_time_i,
    input wire logic wall_time_valid_i,
    input wire logic [`EFR_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic pkt_valid_o,
    output efr_pkg::efr_entry_t pkt_entry_o,
    output logic pkt_wall_time_valid_o,
    output logic [`EFR_CNT_W-1:0] pkt_pending_event_total_o,
    output logic [`EFR_NUM_IN-1:0] pkt_queue_full_flag_o,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [`EFR_PTR_W-1:0] wptr;
        logic [`EFR_PTR_W-1:0] rptr;
        logic [`EFR_CNT_W-1:0] stored;
        logic [`EFR_SEQ_W-1:0] seq_next;
        logic head_valid;
        logic fetch_pend;
        efr_pkg::efr_entry_t head;
        logic [`EFR_NUM_IN-1:0] ovf;
        logic [2:0] irq_st;
        logic [2:0] irq_msk;
        logic [31:0] requested_packet_interval;
        logic [31:0] rpi_cnt;
        logic wall_ok;
        logic [31:0] rdata;
        logic pkt_valid;
        efr_pkg::efr_entry_t pkt_entry;
        logic pkt_wall;
        logic [`EFR_CNT_W-1:0] pkt_pend;
        logic [`EFR_NUM_IN-1:0] pkt_ovf;
        logic irq;
    } efr_state_t;

    efr_state_t st_r;
    efr_state_t st_nxt;
    efr_mem_if mif ();

    efr_mem u_mem (
        .clk_i(clk_i),
        .m(mif)
    );

    ////////////////////////////////////////////////////////////////////////
    // lowest active input wins when several change in one cycle
    function automatic logic [3:0] efr_first(input logic [`EFR_NUM_IN-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = `EFR_NUM_IN - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [`EFR_PTR_W-1:0] efr_inc(input logic [`EFR_PTR_W-1:0] p);
        logic [`EFR_PTR_W-1:0] q;
        q = (p == `EFR_PTR_W'(`EFR_DEPTH - 1)) ? `EFR_PTR_W'h00 : p + `EFR_PTR_W'h01;
        return q;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic new_evt;
    logic [3:0] new_src;
    logic full;
    logic ack_ok;
    logic pop_mem;
    logic [`EFR_CNT_W-1:0] pending;
    efr_pkg::efr_entry_t new_entry;

    always_comb begin
        new_evt = |evt_pulse_i;
        new_src = efr_first(evt_pulse_i);
        // entry in flight from memory still counts as pending
        pending = st_r.stored + ((st_r.head_valid || st_r.fetch_pend) ? `EFR_CNT_W'h01 : `EFR_CNT_W'h00);
        full = (pending == `EFR_CNT_W'(`EFR_DEPTH));
        new_entry.seq = st_r.seq_next;
        new_entry.src = new_src;
        new_entry.pol = evt_level_i[new_src];
        new_entry.sys_ts = coordinated_system_time_i;
        new_entry.wall_ts = wall_time_valid_i ? universal_wall_time_i : 64'h0;
        ack_ok = reg_wr_i && (reg_addr_i == `EFR_A_ACK) && st_r.head_valid
            && (reg_wdata_i[`EFR_SEQ_W-1:0] == st_r.head.seq);
        pop_mem = (!st_r.head_valid || ack_ok) && !st_r.fetch_pend && (st_r.stored != `EFR_CNT_W'h00);
    end

    assign mif.we = new_evt && !full;
    assign mif.waddr = st_r.wptr;
    assign mif.wdata = new_entry;
    assign mif.raddr = st_r.rptr;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [2:0] ev;
        logic tick;
        logic [`EFR_CNT_W-1:0] stored_n;
        ev = 3'h0;
        tick = 1'b0;
        st_nxt = st_r;
        stored_n = st_r.stored;
        st_nxt.wall_ok = wall_time_valid_i;
        // event arrival
        if (new_evt) begin
            if (full) begin
                st_nxt.ovf = st_r.ovf | evt_pulse_i;
                ev[`EFR_IRQ_OVF] = 1'b1;
            end else begin
                st_nxt.wptr = efr_inc(st_r.wptr);
                st_nxt.seq_next = st_r.seq_next + `EFR_SEQ_W'h0001;
                stored_n = stored_n + `EFR_CNT_W'h01;
                ev[`EFR_IRQ_NEW] = 1'b1;
            end
        end
        // acknowledge retires head; stamps and fields drop to zero
        if (ack_ok) begin
            st_nxt.head_valid = 1'b0;
            st_nxt.head = '0;
            // overflow in the ack cycle survives the clear
            st_nxt.ovf = (new_evt && full) ? evt_pulse_i : '0;
        end
        // move next queued entry up, in order
        if (pop_mem) begin
            st_nxt.rptr = efr_inc(st_r.rptr);
            stored_n = stored_n - `EFR_CNT_W'h01;
            st_nxt.fetch_pend = 1'b1;
        end
        st_nxt.stored = stored_n;
        if (st_r.fetch_pend) begin
            st_nxt.fetch_pend = 1'b0;
            st_nxt.head = mif.rdata;
            st_nxt.head_valid = 1'b1;
        end
        // requested packet interval timer
        if (st_r.rpi_cnt == 32'h0) begin
            tick = 1'b1;
            st_nxt.rpi_cnt = (st_r.requested_packet_interval == 32'h0) ? 32'h0 : st_r.requested_packet_interval - 32'h1;
        end else begin
            st_nxt.rpi_cnt = st_r.rpi_cnt - 32'h1;
        end
        st_nxt.pkt_valid = tick;
        if (tick) begin
            st_nxt.pkt_entry = st_r.head_valid ? st_r.head : '0;
            st_nxt.pkt_wall = st_r.wall_ok;
            st_nxt.pkt_pend = pending;
            st_nxt.pkt_ovf = st_r.ovf;
            ev[`EFR_IRQ_SENT] = 1'b1;
        end
        // register port
        st_nxt.rdata = 32'h0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `EFR_A_ACK: st_nxt.rdata = 32'h0;
                `EFR_A_SEQ: st_nxt.rdata = 32'(st_r.head.seq);
                `EFR_A_SRC: st_nxt.rdata = {26'h0, st_r.wall_ok, st_r.head.pol, st_r.head.src};
                `EFR_A_SYS_LO: st_nxt.rdata = st_r.head.sys_ts[31:0];
                `EFR_A_SYS_HI: st_nxt.rdata = st_r.head.sys_ts[63:32];
                `EFR_A_WALL_LO: st_nxt.rdata = st_r.head.wall_ts[31:0];
                `EFR_A_WALL_HI: st_nxt.rdata = st_r.head.wall_ts[63:32];
                `EFR_A_PEND: st_nxt.rdata = 32'(pending);
                `EFR_A_OVF: st_nxt.rdata = 32'(st_r.ovf);
                `EFR_A_IRQ_ST: st_nxt.rdata = 32'(st_r.irq_st);
                `EFR_A_IRQ_MSK: st_nxt.rdata = 32'(st_r.irq_msk);
                `EFR_A_RPI: st_nxt.rdata = st_r.requested_packet_interval;
                default: st_nxt.rdata = 32'h0;
            endcase
        end
        if (reg_wr_i) begin
            case (reg_addr_i)
                `EFR_A_IRQ_ST: st_nxt.irq_st = st_r.irq_st & ~reg_wdata_i[2:0];
                `EFR_A_IRQ_MSK: st_nxt.irq_msk = reg_wdata_i[2:0];
                `EFR_A_RPI: begin
                    st_nxt.requested_packet_interval = reg_wdata_i;
                    st_nxt.rpi_cnt = reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
        // set beats clear
        st_nxt.irq_st = st_nxt.irq_st | ev;
        st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_msk);
        if (!rst_b_i) begin
            st_nxt = '0;
            st_nxt.requested_packet_interval = `EFR_RPI_RST;
            st_nxt.rpi_cnt = `EFR_RPI_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata_o = st_r.rdata;
    assign pkt_valid_o = st_r.pkt_valid;
    assign pkt_entry_o = st_r.pkt_entry;
    assign pkt_wall_time_valid_o = st_r.pkt_wall;
    assign pkt_pending_event_total_o = st_r.pkt_pend;
    assign pkt_queue_full_flag_o = st_r.pkt_ovf;
    assign irq_o = st_r.irq;
endmodule

// *** sim/efr_assertions.sv ***
// Purpose: port checks for the event readout block
// Assumes: packet interval of at least 9 cycles
// Notes: bound to the top module
`timescale 1ns/1ns
`include "efr_regs.svh"
module efr_chk (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [`EFR_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic pkt_valid_o,
    input wire efr_pkg::efr_entry_t pkt_entry_o,
    input wire logic [`EFR_CNT_W-1:0] pkt_pending_event_total_o,
    input wire logic [`EFR_NUM_IN-1:0] pkt_queue_full_flag_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////
    pkt_gap_a: assert property (pkt_valid_o |=> !pkt_valid_o [*8])
        else $error("packet pulses too close");
    empty_zero_a: assert property (pkt_valid_o && pkt_pending_event_total_o == 8'h0 |->
        pkt_entry_o == '0) else $error("empty packet not zero");
    stamp_zero_a: assert property (pkt_valid_o && pkt_pending_event_total_o == 8'h0 |->
        pkt_entry_o.sys_ts == 64'h0 && pkt_entry_o.wall_ts == 64'h0) else $error("stale stamps");
    queue_cap_a: assert property (pkt_pending_event_total_o <= `EFR_DEPTH)
        else $error("pending above depth");
    entry_hold_a: assert property (!pkt_valid_o |-> $stable(pkt_entry_o))
        else $error("entry moved between packets");
    pend_hold_a: assert property (!pkt_valid_o |-> $stable(pkt_pending_event_total_o))
        else $error("pending moved between packets");
    flag_hold_a: assert property (!pkt_valid_o |-> $stable(pkt_queue_full_flag_o))
        else $error("flags moved between packets");
    irq_off_a: assert property (reg_wr_i && reg_addr_i == `EFR_A_IRQ_MSK && reg_wdata_i == 32'h0 |->
        ##2 !irq_o) else $error("irq high with mask clear");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read slot");
    busy_pkt_c: cover property (pkt_valid_o && pkt_pending_event_total_o != 8'h0);
    irq_rise_c: cover property ($rose(irq_o));
    ovf_pkt_c: cover property (pkt_valid_o && pkt_queue_full_flag_o != 16'h0);
endmodule
bind efr_event_fifo_readout efr_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pkt_valid_o(pkt_valid_o), .pkt_entry_o(pkt_entry_o), .pkt_pending_event_total_o(pkt_pending_event_total_o),
    .pkt_queue_full_flag_o(pkt_queue_full_flag_o), .irq_o(irq_o));

// *** sim/efr_ctl_model.sv ***
// Purpose: controller that acknowledges each produced event
// Assumes: ack one cycle after a packet with a pending event
// Notes: keeps only the sequence count of each packet
`timescale 1ns/1ns
`include "efr_regs.svh"
module efr_ctl_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic pkt_valid_i,
    input wire efr_pkg::efr_entry_t pkt_entry_i,
    input wire logic [7:0] pending_i,
    output logic wr_o = 1'b0,
    output logic [3:0] addr_o = 4'h0,
    output logic [31:0] wdata_o = 32'h0
);
    always @(posedge clk_i) begin
        wr_o <= 1'b0;
        if (rst_b_i && en_i && pkt_valid_i && pending_i != 8'h0) begin
            wr_o <= 1'b1;
            addr_o <= `EFR_A_ACK;
            wdata_o <= {16'h0, pkt_entry_i.seq};
        end
    end
endmodule

// *** sim/event_fifo_readout_tb.sv ***
// Purpose: self-checking bench for the event readout block
// Assumes: packet interval set to 20 cycles
// Notes: partner model acks while draining
`timescale 1ns/1ns
`include "efr_regs.svh"
module event_fifo_readout_tb;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wr = 1'b0, rd = 1'b0, ctl_en = 1'b0, wv = 1'b1, p_wr, pv, pw, irq;
    logic [15:0] pulse = '0, lvl = '0, pf;
    logic [63:0] sys_t = '0, wall_t = '0;
    logic [3:0] addr = '0, p_addr;
    logic [31:0] wdata = '0, rdata, p_wdata;
    logic [7:0] pp;
    efr_pkg::efr_entry_t pe, rows[16];
    int error_cnt = 0, num_checks = 0;
    always #5 clk_i = ~clk_i;
    efr_event_fifo_readout uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .evt_pulse_i(pulse), .evt_level_i(lvl),
        .coordinated_system_time_i(sys_t), .universal_wall_time_i(wall_t), .wall_time_valid_i(wv),
        .reg_addr_i(p_wr ? p_addr : addr), .reg_wdata_i(p_wr ? p_wdata : wdata), .reg_wr_i(wr | p_wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .pkt_valid_o(pv), .pkt_entry_o(pe), .pkt_wall_time_valid_o(pw),
        .pkt_pending_event_total_o(pp), .pkt_queue_full_flag_o(pf), .irq_o(irq));
    efr_ctl_model ctl (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(ctl_en), .pkt_valid_i(pv), .pkt_entry_i(pe),
        .pending_i(pp), .wr_o(p_wr), .addr_o(p_addr), .wdata_o(p_wdata));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [148:0] e, input logic [148:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic conclude;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask
    task automatic wpkt;
        int n;
        n = 0;
        @(negedge clk_i);
        while (pv !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        chk("pkt", 1, pv);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        conclude;
    end
    initial begin
        for (int i = 0; i < 16; i++) begin
            rows[i] = '{i[15:0], i[3:0], i[0], 64'h1000 + i, 64'hA0000 - i};
        end
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        wreg(`EFR_A_RPI, 32'h14);
        wreg(`EFR_A_IRQ_MSK, 32'h1);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            pulse <= 16'h1 << i;
            lvl <= {16{rows[i].pol}};
            sys_t <= rows[i].sys_ts;
            wall_t <= rows[i].wall_ts;
            @(posedge clk_i);
            pulse <= '0;
        end
        rchk("pend", `EFR_A_PEND, 32'h10);
        chk("irq", 1, irq);
        wreg(`EFR_A_ACK, 32'h5);
        rchk("seq", `EFR_A_SEQ, 32'h0);
        rchk("src", `EFR_A_SRC, 32'h20);
        rchk("syslo", `EFR_A_SYS_LO, 32'h1000);
        rchk("wallhi", `EFR_A_WALL_HI, 32'h0);
        rchk("walllo", `EFR_A_WALL_LO, 32'h000A0000);
        rchk("hole", 4'hF, 32'h0);
        wreg(`EFR_A_IRQ_ST, 32'h1);
        repeat (3) @(negedge clk_i);
        chk("irq", 0, irq);
        wreg(`EFR_A_IRQ_MSK, 32'h4);
        repeat (3) @(negedge clk_i);
        chk("irq", 1, irq);
        wreg(`EFR_A_IRQ_MSK, 32'h0);
        ctl_en <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            wpkt;
            chk("entry", rows[k], pe);
            chk("pend", 16 - k, pp);
            chk("wallok", 1, pw);
        end
        wpkt;
        chk("empty", 0, pe);
        ctl_en <= 1'b0;
        @(posedge clk_i);
        pulse <= 16'h0008;
        repeat (161) @(posedge clk_i);
        pulse <= '0;
        rchk("ovf", `EFR_A_OVF, 32'h8);
        rchk("pend", `EFR_A_PEND, 32'hA0);
        rchk("seq", `EFR_A_SEQ, 32'h10);
        wpkt;
        chk("flags", 16'h0008, pf);
        wreg(`EFR_A_ACK, 32'h10);
        repeat (3) @(posedge clk_i);
        rchk("seq", `EFR_A_SEQ, 32'h11);
        rchk("ovf", `EFR_A_OVF, 32'h0);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rchk("pend", `EFR_A_PEND, 32'h0);
        chk("pktpend", 0, pp);
        // wall time absent: stamp stored as zero, flag low
        @(posedge clk_i);
        wv <= 1'b0;
        pulse <= 16'h0004;
        @(posedge clk_i);
        pulse <= '0;
        repeat (3) @(posedge clk_i);
        rchk("wall0", `EFR_A_WALL_LO, 32'h0);
        rchk("src2", `EFR_A_SRC, 32'h12);
        conclude;
    end
endmodule
